/* inc/dao_pkg.sv */
// Purpose: Shared constants and types for the dual converter output port
// Assumes: 8-bit register port, 16-bit sample words
// Notes:   Register offsets index the mode control register space
package dao_pkg;

   // Widths
   localparam int DAO_WORD_W  = 16;
   localparam int DAO_ADDR_W  = 8;
   localparam int DAO_DATA_W  = 8;
   localparam int DAO_UA_W    = 14;

   // Register offsets
   localparam logic [7:0] DAO_REG_OUT_MODE  = 8'h03;
   localparam logic [7:0] DAO_REG_CLK_PHASE = 8'h05;
   localparam logic [7:0] DAO_REG_STATUS    = 8'h06;

   // Output mode register fields
   localparam int DAO_DRV_LSB  = 0;
   localparam int DAO_TERM_BIT = 3;
   localparam int DAO_FMT_LSB  = 4;

   // Clock phase register field
   localparam int DAO_PHASE_LSB = 0;

   // Status register fields
   localparam int DAO_ST_FMT_LSB = 0;
   localparam int DAO_ST_PAR_BIT = 2;
   localparam int DAO_ST_CLK_BIT = 3;
   localparam int DAO_ST_CNT_LSB = 4;

   // Reset values
   localparam logic [7:0] DAO_OUT_MODE_RST  = 8'h04;
   localparam logic [7:0] DAO_CLK_PHASE_RST = 8'h00;

   // Structure defaults
   localparam int DAO_PHASE_TAPS = 4;
   localparam int DAO_PIPE_DEPTH = 2;

   // Output formats
   typedef enum logic [1:0] {
      DAO_FMT_FULL     = 2'h0,
      DAO_FMT_DDR_CMOS = 2'h1,
      DAO_FMT_DDR_LVDS = 2'h2
   } dao_fmt_t;

   // Output half states, Gray along low/high alternation
   typedef enum logic [1:0] {
      DAO_PH_IDLE = 2'h0,
      DAO_PH_LOW  = 2'h1,
      DAO_PH_HIGH = 2'h3
   } dao_half_t;

   // Format field decode, unused code falls back to full rate
   function automatic dao_fmt_t dao_decode_fmt(input logic [1:0] f);
      dao_fmt_t r;
      r = DAO_FMT_FULL;
      if (f == 2'h1) begin
         r = DAO_FMT_DDR_CMOS;
      end else if (f == 2'h2) begin
         r = DAO_FMT_DDR_LVDS;
      end
      return r;
   endfunction

   // Drive code to driver current in microamperes
   function automatic logic [13:0] dao_drive_ua(input logic [2:0] code);
      logic [13:0] r;
      r = 14'hDAC;
      case (code)
         3'h0: r = 14'h6D6;
         3'h1: r = 14'h834;
         3'h2: r = 14'h9C4;
         3'h3: r = 14'hBB8;
         3'h5: r = 14'hFA0;
         3'h6: r = 14'h1194;
         default: r = 14'hDAC;
      endcase
      return r;
   endfunction

endpackage

/* inc/dao_ser_if.sv */
// Purpose: Carries one channel word to its pair serializer
// Assumes: Word width even
// Notes:   Lines are flip-flop outputs of the serializer
interface dao_ser_if #(parameter int W = 16);
   logic [W-1:0]   word;
   logic           load;
   logic           odd_half;
   logic           clear;
   logic [W/2-1:0] lines;

   modport drv (output word, output load, output odd_half, output clear,
                input lines);
   modport ser (input word, input load, input odd_half, input clear,
                output lines);
endinterface

/* hw/dao_ddr_ser.sv */
// Purpose: Packs a sample word onto half as many lines, two bits per line
// Assumes: Load pulses mark each half of the forwarded clock
// Notes:   Line i carries bit 2i then bit 2i+1
module dao_ddr_ser
   import dao_pkg::*;
#(
   parameter int W = DAO_WORD_W
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Word and lines
   dao_ser_if.ser   sif
);

   genvar i;
   generate
      for (i = 0; i < W / 2; i++) begin : g_line
         // Even bit in low half, odd bit in high half
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               sif.lines[i] <= 1'b0;
            end else if (sif.clear) begin
               sif.lines[i] <= 1'b0;
            end else if (sif.load) begin
               sif.lines[i] <= sif.odd_half ? sif.word[2*i+1]
                                            : sif.word[2*i];
            end
         end
      end
   endgenerate

endmodule

/* hw/dao_ddr_port.sv */
// Purpose: Output formatting of a two-channel 16-bit converter
// Assumes: Encode clock pin is slower than a quarter of core_clk
// Notes:   Forwarded clock follows the sampled encode clock
//
// Operation
// - Two word bits per line per period
// - Even bits while true clock low
// - Odd bits while true clock high
// - Data change on both clock edges
// - Complement clock inverts true clock
// - True clock phase delay is programmable
// - Range flag high on over or under range
// - Both range flags share one line
// - Channel two low, channel one high
// - Differential pairs use same bit order
// - Differential drive current is programmable
// - Optional on-chip pair termination
// - Both channels sampled at one instant
// - Full, DDR single-ended, DDR differential selectable
// - Sixteen-bit word per channel conversion
// - Controller writes mode control registers
// - Flag latency equals data latency
// - Output mode register selects format, drive
// - Seven current levels, 3.5 mA default
// - Termination doubles driver current
module dao_ddr_port
   import dao_pkg::*;
#(
   parameter int PIPE_DEPTH  = DAO_PIPE_DEPTH,
   parameter int PHASE_TAPS  = DAO_PHASE_TAPS
) (
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // Encode clock and programming straps
   input  wire logic                  enc_clk,
   input  wire logic                  par_mode_pin,
   input  wire logic                  par_lvds_pin,
   // Converter core samples
   input  wire logic [DAO_WORD_W-1:0] ch1_sample,
   input  wire logic [DAO_WORD_W-1:0] ch2_sample,
   input  wire logic                  ch1_over,
   input  wire logic                  ch2_over,
   // Register port
   input  wire logic [DAO_ADDR_W-1:0] reg_addr,
   input  wire logic [DAO_DATA_W-1:0] reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [DAO_DATA_W-1:0] reg_rdata,
   // Full rate outputs
   output logic      [DAO_WORD_W-1:0] ch1_word,
   output logic      [DAO_WORD_W-1:0] ch2_word,
   output logic                       ch1_range_flag,
   output logic                       ch2_range_flag,
   // Double data rate outputs
   output logic      [DAO_WORD_W/2-1:0] ch1_ddr_lines,
   output logic      [DAO_WORD_W/2-1:0] ch2_ddr_lines,
   output logic                       shared_range_flag,
   // Forwarded clock
   output logic                       fwd_clk_true,
   output logic                       fwd_clk_comp,
   // Differential driver settings
   output logic                       lvds_en,
   output logic                       lvds_term_en,
   output logic      [DAO_UA_W-1:0]   lvds_drive_ua
);

   localparam int PW = $clog2(PHASE_TAPS);

   // Synchronisers
   logic                  enc_meta;
   logic                  enc_sync;
   logic                  enc_prev;
   logic [1:0]            strap_meta;
   logic [1:0]            strap_sync;
   logic                  enc_rise;
   logic                  enc_fall;

   // Registers
   logic [DAO_DATA_W-1:0] output_mode_register;
   logic [DAO_DATA_W-1:0] clock_phase_register;
   dao_fmt_t              fmt;
   logic                  ddr;
   logic [3:0]            sample_cnt;

   // Pipeline and output hold
   logic [DAO_WORD_W-1:0] pipe_w1 [PIPE_DEPTH];
   logic [DAO_WORD_W-1:0] pipe_w2 [PIPE_DEPTH];
   logic                  pipe_o1 [PIPE_DEPTH];
   logic                  pipe_o2 [PIPE_DEPTH];
   logic [DAO_WORD_W-1:0] hold_w1;
   logic [DAO_WORD_W-1:0] hold_w2;
   logic                  hold_o1;
   dao_half_t             half;
   logic                  half_rise;

   // Forwarded clock taps
   logic [PHASE_TAPS-1:0] ph_line;
   logic [PW-1:0]         phase_sel;

   dao_ser_if #(.W(DAO_WORD_W)) ser1 ();
   dao_ser_if #(.W(DAO_WORD_W)) ser2 ();

   // Encode clock pin, two flip-flops then edge detect
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enc_meta <= 1'b0;
         enc_sync <= 1'b0;
         enc_prev <= 1'b0;
      end else begin
         enc_meta <= enc_clk;
         enc_sync <= enc_meta;
         enc_prev <= enc_sync;
      end
   end

   assign enc_rise = enc_sync & ~enc_prev;
   assign enc_fall = ~enc_sync & enc_prev;
   assign half_rise = enc_rise & (half == DAO_PH_LOW);

   // Programming mode straps
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         strap_meta <= 2'h0;
         strap_sync <= 2'h0;
      end else begin
         strap_meta <= {par_lvds_pin, par_mode_pin};
         strap_sync <= strap_meta;
      end
   end

   // Mode control register writes
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         output_mode_register <= DAO_OUT_MODE_RST;
         clock_phase_register <= DAO_CLK_PHASE_RST;
      end else if (reg_wr) begin
         if (reg_addr == DAO_REG_OUT_MODE) begin
            output_mode_register <= reg_wdata;
         end
         if (reg_addr == DAO_REG_CLK_PHASE) begin
            clock_phase_register <= reg_wdata;
         end
      end
   end

   // Effective format: serial mode uses the register, parallel the strap
   always_comb begin
      if (strap_sync[0]) begin
         fmt = strap_sync[1] ? DAO_FMT_DDR_LVDS : DAO_FMT_FULL;
      end else begin
         fmt = dao_decode_fmt(
                  output_mode_register[DAO_FMT_LSB +: 2]);
      end
   end

   assign ddr = (fmt != DAO_FMT_FULL);
   assign phase_sel = clock_phase_register[DAO_PHASE_LSB +: PW];

   // Register reads, data in the following cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            DAO_REG_OUT_MODE:  reg_rdata <= output_mode_register;
            DAO_REG_CLK_PHASE: reg_rdata <= clock_phase_register;
            DAO_REG_STATUS: begin
               reg_rdata <= '0;
               reg_rdata[DAO_ST_FMT_LSB +: 2] <= fmt;
               reg_rdata[DAO_ST_PAR_BIT]      <= strap_sync[0];
               reg_rdata[DAO_ST_CLK_BIT]      <= fwd_clk_true;
               reg_rdata[DAO_ST_CNT_LSB +: 4] <= sample_cnt;
            end
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // Both channels captured on the same encode edge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            pipe_w1[i] <= '0;
            pipe_w2[i] <= '0;
            pipe_o1[i] <= 1'b0;
            pipe_o2[i] <= 1'b0;
         end
      end else if (enc_rise) begin
         pipe_w1[0] <= ch1_sample;
         pipe_w2[0] <= ch2_sample;
         pipe_o1[0] <= ch1_over;
         pipe_o2[0] <= ch2_over;
         for (int i = 1; i < PIPE_DEPTH; i++) begin
            pipe_w1[i] <= pipe_w1[i-1];
            pipe_w2[i] <= pipe_w2[i-1];
            pipe_o1[i] <= pipe_o1[i-1];
            pipe_o2[i] <= pipe_o2[i-1];
         end
      end
   end

   // Conversion counter for status
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sample_cnt <= 4'h0;
      end else if (enc_rise) begin
         sample_cnt <= sample_cnt + 4'h1;
      end
   end

   // Half tracking: low half opens each output period
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         half <= DAO_PH_IDLE;
      end else begin
         unique case (half)
            DAO_PH_IDLE: if (enc_fall) half <= DAO_PH_LOW;
            DAO_PH_LOW:  if (enc_rise) half <= DAO_PH_HIGH;
            DAO_PH_HIGH: if (enc_fall) half <= DAO_PH_LOW;
            default:     half <= DAO_PH_IDLE;
         endcase
      end
   end

   // Word held for the whole output period
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hold_w1 <= '0;
         hold_w2 <= '0;
         hold_o1 <= 1'b0;
      end else if (enc_fall) begin
         hold_w1 <= pipe_w1[PIPE_DEPTH-1];
         hold_w2 <= pipe_w2[PIPE_DEPTH-1];
         hold_o1 <= pipe_o1[PIPE_DEPTH-1];
      end
   end

   // Full rate outputs change on the falling edge only
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ch1_word       <= '0;
         ch2_word       <= '0;
         ch1_range_flag <= 1'b0;
         ch2_range_flag <= 1'b0;
      end else if (ddr) begin
         ch1_word       <= '0;
         ch2_word       <= '0;
         ch1_range_flag <= 1'b0;
         ch2_range_flag <= 1'b0;
      end else if (enc_fall) begin
         ch1_word       <= pipe_w1[PIPE_DEPTH-1];
         ch2_word       <= pipe_w2[PIPE_DEPTH-1];
         ch1_range_flag <= pipe_o1[PIPE_DEPTH-1];
         ch2_range_flag <= pipe_o2[PIPE_DEPTH-1];
      end
   end

   // Serializer feed: new word at falling edge, held word at rising
   always_comb begin
      ser1.word     = enc_fall ? pipe_w1[PIPE_DEPTH-1] : hold_w1;
      ser2.word     = enc_fall ? pipe_w2[PIPE_DEPTH-1] : hold_w2;
      ser1.load     = ddr & (enc_fall | half_rise);
      ser2.load     = ddr & (enc_fall | half_rise);
      ser1.odd_half = enc_rise;
      ser2.odd_half = enc_rise;
      ser1.clear    = ~ddr;
      ser2.clear    = ~ddr;
   end

   dao_ddr_ser #(.W(DAO_WORD_W)) u_ser1 (
      .core_clk (core_clk),
      .rst      (rst),
      .sif      (ser1.ser)
   );

   dao_ddr_ser #(.W(DAO_WORD_W)) u_ser2 (
      .core_clk (core_clk),
      .rst      (rst),
      .sif      (ser2.ser)
   );

   // Same lines serve single-ended and differential DDR
   assign ch1_ddr_lines = ser1.lines;
   assign ch2_ddr_lines = ser2.lines;

   // Shared range flag: channel two low half, channel one high half
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shared_range_flag <= 1'b0;
      end else if (!ddr) begin
         shared_range_flag <= 1'b0;
      end else if (enc_fall) begin
         shared_range_flag <= pipe_o2[PIPE_DEPTH-1];
      end else if (enc_rise) begin
         shared_range_flag <= hold_o1;
      end
   end

   // Forwarded clock delay taps
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ph_line <= '0;
      end else begin
         ph_line <= {ph_line[PHASE_TAPS-2:0], enc_sync};
      end
   end

   // Tap zero edges coincide with data changes
   assign fwd_clk_true = ph_line[phase_sel];
   assign fwd_clk_comp = ~ph_line[phase_sel];

   // Differential driver settings
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lvds_en       <= 1'b0;
         lvds_term_en  <= 1'b0;
         lvds_drive_ua <= '0;
      end else begin
         lvds_en      <= (fmt == DAO_FMT_DDR_LVDS);
         lvds_term_en <= (fmt == DAO_FMT_DDR_LVDS)
                         & output_mode_register[DAO_TERM_BIT];
         if (fmt != DAO_FMT_DDR_LVDS) begin
            lvds_drive_ua <= '0;
         end else if (output_mode_register[DAO_TERM_BIT]) begin
            lvds_drive_ua <= dao_drive_ua(
               output_mode_register[DAO_DRV_LSB +: 3]) << 1;
         end else begin
            lvds_drive_ua <= dao_drive_ua(
               output_mode_register[DAO_DRV_LSB +: 3]);
         end
      end
   end

endmodule

/* bench/dao_rx_model.sv */
// Purpose: Capturing receiver on the far side of the DDR link
// Assumes: Forwarded clock halves last two core cycles or more
// Notes:   Rebuilds one word pair per forwarded clock period
module dao_rx_model
   import dao_pkg::*;
(
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   // Forwarded link
   input  wire logic                    fwd_clk_true,
   input  wire logic [DAO_WORD_W/2-1:0] ch1_ddr_lines,
   input  wire logic [DAO_WORD_W/2-1:0] ch2_ddr_lines,
   input  wire logic                    shared_range_flag,
   // Rebuilt words
   output logic      [DAO_WORD_W-1:0]   ch1_rx,
   output logic      [DAO_WORD_W-1:0]   ch2_rx,
   output logic                         rx_flag1,
   output logic                         rx_flag2,
   output logic      [7:0]              rx_cnt
);
   logic                    clk_q;
   logic [DAO_WORD_W/2-1:0] ev1;
   logic [DAO_WORD_W/2-1:0] ev2;
   logic                    fl2;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clk_q <= 1'b0;
         ev1 <= '0;
         ev2 <= '0;
         fl2 <= 1'b0;
         ch1_rx <= '0;
         ch2_rx <= '0;
         rx_flag1 <= 1'b0;
         rx_flag2 <= 1'b0;
         rx_cnt <= 8'h00;
      end else begin
         clk_q <= fwd_clk_true;
         if (clk_q && !fwd_clk_true) begin
            ev1 <= ch1_ddr_lines;
            ev2 <= ch2_ddr_lines;
            fl2 <= shared_range_flag;
         end
         if (!clk_q && fwd_clk_true) begin
            for (int i = 0; i < DAO_WORD_W/2; i++) begin
               ch1_rx[2*i] <= ev1[i];
               ch1_rx[2*i+1] <= ch1_ddr_lines[i];
               ch2_rx[2*i] <= ev2[i];
               ch2_rx[2*i+1] <= ch2_ddr_lines[i];
            end
            rx_flag1 <= shared_range_flag;
            rx_flag2 <= fl2;
            rx_cnt <= rx_cnt + 8'h01;
         end
      end
   end
endmodule

/* bench/dao_ddr_port_properties.sv */
// Purpose: Port checker for the dual converter output port
// Assumes: Single core_clk domain
// Notes:   Mirrors output mode writes for readback checks
module dao_props
   import dao_pkg::*;
#(
   parameter int PIPE_DEPTH = DAO_PIPE_DEPTH,
   parameter int PHASE_TAPS = DAO_PHASE_TAPS
) (
   // Clock and reset
   input wire logic                    core_clk,
   input wire logic                    rst,
   // Register port
   input wire logic [DAO_ADDR_W-1:0]   reg_addr,
   input wire logic [DAO_DATA_W-1:0]   reg_wdata,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [DAO_DATA_W-1:0]   reg_rdata,
   // Outputs
   input wire logic [DAO_WORD_W-1:0]   ch1_word,
   input wire logic [DAO_WORD_W-1:0]   ch2_word,
   input wire logic                    ch1_range_flag,
   input wire logic                    ch2_range_flag,
   input wire logic [DAO_WORD_W/2-1:0] ch1_ddr_lines,
   input wire logic [DAO_WORD_W/2-1:0] ch2_ddr_lines,
   input wire logic                    shared_range_flag,
   input wire logic                    fwd_clk_true,
   input wire logic                    fwd_clk_comp,
   input wire logic                    lvds_en,
   input wire logic                    lvds_term_en,
   input wire logic [DAO_UA_W-1:0]     lvds_drive_ua
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] mode_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mode_q <= DAO_OUT_MODE_RST[5:0];
      end else if (reg_wr && reg_addr == DAO_REG_OUT_MODE) begin
         mode_q <= reg_wdata[5:0];
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   comp_inverse_a: assert property (fwd_clk_comp == !fwd_clk_true)
      else $error("complement clock not inverse");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   mode_readback_a: assert property (
      reg_rd && reg_addr == DAO_REG_OUT_MODE
      |=> reg_rdata[5:0] == $past(mode_q)) else $error("mode readback");
   lvds_idle_a: assert property (
      !lvds_en |-> lvds_drive_ua == 14'h0000 && !lvds_term_en)
      else $error("drive settings outside differential mode");
   term_double_a: assert property (
      lvds_term_en |-> lvds_drive_ua >= 14'h0DAC)
      else $error("termination current not doubled");
   full_quiet_a: assert property (
      |{ch1_word, ch2_word, ch1_range_flag, ch2_range_flag}
      |-> ch1_ddr_lines == 8'h00 && ch2_ddr_lines == 8'h00
          && !shared_range_flag) else $error("both formats active");
   drive_min_a: assert property (
      reg_wr && reg_addr == DAO_REG_OUT_MODE && reg_wdata == 8'h20
      |-> ##[1:3] lvds_drive_ua == 14'h06D6) else $error("drive code 0");
   lvds_fmt_a: assert property (
      mode_q[5:4] == 2'h2 [*3] |-> lvds_en)
      else $error("differential format not enabled");

   cover property (lvds_term_en);
   cover property (reg_rd && reg_addr == DAO_REG_STATUS);
   cover property ($rose(fwd_clk_true) && |ch1_ddr_lines);
endmodule

bind dao_ddr_port dao_props #(.PIPE_DEPTH(PIPE_DEPTH),
   .PHASE_TAPS(PHASE_TAPS)) u_props (.core_clk(core_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch1_word(ch1_word),
   .ch2_word(ch2_word), .ch1_range_flag(ch1_range_flag),
   .ch2_range_flag(ch2_range_flag), .ch1_ddr_lines(ch1_ddr_lines),
   .ch2_ddr_lines(ch2_ddr_lines), .shared_range_flag(shared_range_flag),
   .fwd_clk_true(fwd_clk_true), .fwd_clk_comp(fwd_clk_comp),
   .lvds_en(lvds_en), .lvds_term_en(lvds_term_en),
   .lvds_drive_ua(lvds_drive_ua));

/* bench/dao_ddr_port_tb.sv */
// Purpose: Self-checking bench for the dual converter output port
// Assumes: Encode clock 160 ns, core clock 20 ns
// Notes:   Receiver model rebuilds DDR words
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
   n_mismatch++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module dao_ddr_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dao_pkg::*;
   logic        core_clk, rst, enc_clk, par_mode_pin, par_lvds_pin;
   logic [15:0] ch1_sample, ch2_sample, ch1_word, ch2_word, ch1_rx, ch2_rx;
   logic        ch1_over, ch2_over, ch1_range_flag, ch2_range_flag;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, ch1_ddr_lines;
   logic [7:0]  ch2_ddr_lines, rx_cnt, d, l1_q;
   logic        reg_wr, reg_rd, shared_range_flag, fwd_clk_true, ck_q;
   logic        fwd_clk_comp, lvds_en, lvds_term_en, rx_flag1, rx_flag2;
   logic [13:0] lvds_drive_ua;
   logic [13:0] ua_tab [8] = '{14'h06D6, 14'h0834, 14'h09C4, 14'h0BB8,
                               14'h0DAC, 14'h0FA0, 14'h1194, 14'h0DAC};
   int          n_mismatch, tests_run, cyc, last_chg, gap;

   dao_ddr_port dut (.core_clk(core_clk), .rst(rst), .enc_clk(enc_clk),
      .par_mode_pin(par_mode_pin), .par_lvds_pin(par_lvds_pin),
      .ch1_sample(ch1_sample), .ch2_sample(ch2_sample),
      .ch1_over(ch1_over), .ch2_over(ch2_over), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ch1_word(ch1_word), .ch2_word(ch2_word),
      .ch1_range_flag(ch1_range_flag), .ch2_range_flag(ch2_range_flag),
      .ch1_ddr_lines(ch1_ddr_lines), .ch2_ddr_lines(ch2_ddr_lines),
      .shared_range_flag(shared_range_flag), .fwd_clk_true(fwd_clk_true),
      .fwd_clk_comp(fwd_clk_comp), .lvds_en(lvds_en),
      .lvds_term_en(lvds_term_en), .lvds_drive_ua(lvds_drive_ua));
   dao_rx_model u_rx (.core_clk(core_clk), .rst(rst),
      .fwd_clk_true(fwd_clk_true), .ch1_ddr_lines(ch1_ddr_lines),
      .ch2_ddr_lines(ch2_ddr_lines), .shared_range_flag(shared_range_flag),
      .ch1_rx(ch1_rx), .ch2_rx(ch2_rx), .rx_flag1(rx_flag1),
      .rx_flag2(rx_flag2), .rx_cnt(rx_cnt));

   always #10 core_clk = ~core_clk;
   initial begin
      enc_clk = 1'b0;
      #7;
      forever #80 enc_clk = ~enc_clk;
   end
   // Gap from last data change to the forwarded clock change
   always @(posedge core_clk) begin
      cyc++;
      if (ch1_ddr_lines !== l1_q) last_chg = cyc;
      if (fwd_clk_true !== ck_q) gap = cyc - last_chg;
      l1_q = ch1_ddr_lines;
      ck_q = fwd_clk_true;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   task automatic put(input logic [15:0] a, b, input logic o1, o2);
      @(posedge core_clk);
      ch1_sample <= a;
      ch2_sample <= b;
      ch1_over <= o1;
      ch2_over <= o2;
   endtask
   task automatic wait_rx(input logic [7:0] n);
      logic [7:0] st;
      st = rx_cnt;
      for (int k = 0; k < 400; k++) begin
         @(posedge core_clk);
         if (rx_cnt - st >= n) return;
      end
      n_mismatch++;
      $display("[FAIL] rx words exp %0d got %0d", n, rx_cnt - st);
      conclude();
   endtask
   task automatic ddr_chk(input logic [15:0] a, b, input logic o1, o2);
      put(a, b, o1, o2);
      wait_rx(8'h04);
      `CHK("ch1 rx", a, ch1_rx)
      `CHK("ch2 rx", b, ch2_rx)
      `CHK("flag1", o1, rx_flag1)
      `CHK("flag2", o2, rx_flag2)
   endtask

   initial begin
      {core_clk, par_mode_pin, par_lvds_pin, reg_wr, reg_rd} = '0;
      {ch1_sample, ch2_sample, ch1_over, ch2_over} = '0;
      {reg_addr, reg_wdata} = '0;
      rst = 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd(DAO_REG_OUT_MODE, d);
      `CHK("mode reset", DAO_OUT_MODE_RST, d)
      rd(DAO_REG_CLK_PHASE, d);
      `CHK("phase reset", DAO_CLK_PHASE_RST, d)
      rd(8'h40, d);
      `CHK("unmapped", 8'h00, d)
      $display("done: registers");
      put(16'h1234, 16'hFEDC, 1'b1, 1'b0);
      for (int k = 0; k < 100 && ch1_word !== 16'h1234; k++)
         @(posedge core_clk);
      `CHK("ch1 word", 16'h1234, ch1_word)
      `CHK("ch2 word", 16'hFEDC, ch2_word)
      `CHK("ch1 flag", 1'b1, ch1_range_flag)
      `CHK("ch2 flag", 1'b0, ch2_range_flag)
      `CHK("ddr idle", 8'h00, ch1_ddr_lines)
      $display("done: full rate");
      wr(DAO_REG_OUT_MODE, 8'h14);
      ddr_chk(16'hA5C3, 16'h3C5A, 1'b1, 1'b0);
      ddr_chk(16'h8001, 16'h7FFE, 1'b0, 1'b1);
      rd(DAO_REG_STATUS, d);
      `CHK("status fmt", 2'h1, d[1:0])
      `CHK("cmos lvds", 1'b0, lvds_en)
      $display("done: ddr cmos");
      for (int t = 0; t < 2; t++) begin
         for (int c = 0; c < 8; c++) begin
            wr(DAO_REG_OUT_MODE, 8'h20 | 8'(t << 3) | 8'(c));
            repeat (3) @(posedge core_clk);
            `CHK("lvds en", 1'b1, lvds_en)
            `CHK("term", t[0], lvds_term_en)
            `CHK("drive", ua_tab[c] << t, lvds_drive_ua)
         end
      end
      ddr_chk(16'h0FF0, 16'hC33C, 1'b1, 1'b1);
      $display("done: ddr lvds");
      wr(DAO_REG_OUT_MODE, 8'h14);
      put(16'h5555, 16'h5555, 1'b0, 1'b0);
      for (int p = 0; p < 4; p += 2) begin
         wr(DAO_REG_CLK_PHASE, 8'(p));
         wait_rx(8'h03);
         `CHK("clock gap", p, gap)
         rd(DAO_REG_CLK_PHASE, d);
         `CHK("phase", 8'(p), d)
      end
      $display("done: phase");
      wr(DAO_REG_OUT_MODE, 8'h30);
      rd(DAO_REG_STATUS, d);
      `CHK("fmt code 3", 2'h0, d[1:0])
      @(posedge core_clk);
      par_mode_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(DAO_REG_STATUS, d);
      `CHK("strap full", 3'h4, d[2:0])
      @(posedge core_clk);
      par_lvds_pin <= 1'b1;
      repeat (5) @(posedge core_clk);
      rd(DAO_REG_STATUS, d);
      `CHK("strap lvds", 3'h6, d[2:0])
      `CHK("strap lvds en", 1'b1, lvds_en)
      `CHK("strap drive", 14'h06D6, lvds_drive_ua)
      $display("done: straps");
      conclude();
   end
   initial begin
      repeat (60000) @(posedge core_clk);
      n_mismatch++;
      $display("[FAIL] run time exp end got timeout");
      conclude();
   end
endmodule
